// file: core/gtm_pkg.sv
// package for the gated timer with period-match companion
`default_nettype none
package gtm_pkg;
  localparam int unsigned AXI_AW = 8;
  // register byte offsets
  localparam logic [7:0] OFS_COUNT_LOW     = 8'h00;
  localparam logic [7:0] OFS_COUNT_HIGH    = 8'h04;
  localparam logic [7:0] OFS_GATE_CONTROL  = 8'h08;
  localparam logic [7:0] OFS_TIMER_CONTROL = 8'h0c;
  localparam logic [7:0] OFS_SHORT_COUNT   = 8'h10;
  localparam logic [7:0] OFS_PERIOD        = 8'h14;
  localparam logic [7:0] OFS_SHORT_CONTROL = 8'h18;
  localparam logic [7:0] OFS_FLAGS         = 8'h1c;
  localparam logic [7:0] OFS_IRQ_ENABLE    = 8'h20;
  localparam logic [7:0] OFS_TRIGGER       = 8'h24;
  // gate control fields
  localparam int unsigned GC_SEL_LSB   = 0;
  localparam int unsigned GC_VAL       = 2;
  localparam int unsigned GC_GO        = 3;
  localparam int unsigned GC_SPM       = 4;
  localparam int unsigned GC_TM        = 5;
  localparam int unsigned GC_POL       = 6;
  localparam int unsigned GC_GE        = 7;
  // timer control fields
  localparam int unsigned TC_ON        = 0;
  // short timer control fields
  localparam int unsigned SC_PS_LSB    = 0;
  localparam int unsigned SC_ON        = 2;
  localparam int unsigned SC_POST_LSB  = 3;
  // flag / enable bit positions
  localparam int unsigned FL_OVF       = 0;
  localparam int unsigned FL_GATE      = 1;
  localparam int unsigned FL_SHORT     = 2;
  // trigger register fields
  localparam int unsigned TR_MODE_LSB  = 0;
  localparam int unsigned TR_ASYNC     = 4;
  localparam logic [3:0] SPECIAL_EVENT_MODE = 4'hb;
  // gate source codes
  localparam logic [1:0] SRC_PIN   = 2'h0;
  localparam logic [1:0] SRC_MATCH = 2'h1;
  localparam logic [1:0] SRC_CMP1  = 2'h2;
  localparam logic [1:0] SRC_CMP2  = 2'h3;
  // reset values and counter maximum
  localparam logic [7:0]  RST_PERIOD = 8'hff;
  localparam logic [7:0]  RST_CTRL   = 8'h00;
  localparam logic [15:0] RST_COUNT  = 16'h0000;
  localparam logic [15:0] COUNT_MAX  = 16'hffff;
  // instruction clock is a quarter of the system clock
  localparam int unsigned INSTR_DIV  = 4;
  localparam logic [1:0] AXI_OKAY   = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;
endpackage : gtm_pkg
`default_nettype wire

// file: core/gtm_top.sv
// gated 16-bit timer with 8-bit period-match companion, axi4-lite slave
//
// Design decisions made here: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module gtm_top
  import gtm_pkg::*;
(
  input  wire logic                aclk,
  input  wire logic                aresetn,
  input  wire logic [AXI_AW-1:0]   s_axi_awaddr,
  input  wire logic [2:0]          s_axi_awprot,
  input  wire logic                s_axi_awvalid,
  output var  logic                s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output var  logic                s_axi_wready,
  output var  logic [1:0]          s_axi_bresp,
  output var  logic                s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire logic [AXI_AW-1:0]   s_axi_araddr,
  input  wire logic [2:0]          s_axi_arprot,
  input  wire logic                s_axi_arvalid,
  output var  logic                s_axi_arready,
  output var  logic [31:0]         s_axi_rdata,
  output var  logic [1:0]          s_axi_rresp,
  output var  logic                s_axi_rvalid,
  input  wire logic                s_axi_rready,
  input  wire logic                gate_input_pin,
  input  wire logic                cmp1_out,
  input  wire logic                cmp2_out,
  input  wire logic                compare_trigger,
  output var  logic                overflow_irq,
  output var  logic                gate_event_irq,
  output var  logic                short_timer_irq
);
  import gtm_pkg::*;

  // ---------------- axi4-lite slave ----------------
  logic [AXI_AW-1:0] awaddr_q;
  logic              aw_have_q, w_have_q;
  logic [31:0]       wdata_q;
  logic [3:0]        wstrb_q;
  logic              wr_fire, rd_fire;
  logic [31:0]       rd_val;
  logic              rd_ok;

  function automatic logic known_ofs(input logic [AXI_AW-1:0] a);
    case (a)
      OFS_COUNT_LOW, OFS_COUNT_HIGH, OFS_GATE_CONTROL, OFS_TIMER_CONTROL,
      OFS_SHORT_COUNT, OFS_PERIOD, OFS_SHORT_CONTROL, OFS_FLAGS,
      OFS_IRQ_ENABLE, OFS_TRIGGER: known_ofs = 1'b1;
      default: known_ofs = 1'b0;
    endcase
  endfunction : known_ofs

  // write to a register: address hit and low byte lane enabled
  function automatic logic wr_hit(input logic [AXI_AW-1:0] a, input logic [7:0] ofs,
                                  input logic fire, input logic [3:0] strb);
    wr_hit = fire && (a == ofs) && strb[0];
  endfunction : wr_hit

  assign wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;
  assign rd_fire = s_axi_arvalid && s_axi_arready;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q     <= 1'b0;
      awaddr_q      <= '0;
      s_axi_awready <= 1'b1;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_have_q     <= 1'b1;
      awaddr_q      <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end else if (wr_fire) begin
      aw_have_q     <= 1'b0;
    end else if (!aw_have_q && !s_axi_bvalid) begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_have_q     <= 1'b0;
      wdata_q      <= '0;
      wstrb_q      <= '0;
      s_axi_wready <= 1'b1;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_have_q     <= 1'b1;
      wdata_q      <= s_axi_wdata;
      wstrb_q      <= s_axi_wstrb;
      s_axi_wready <= 1'b0;
    end else if (wr_fire) begin
      w_have_q     <= 1'b0;
    end else if (!w_have_q && !s_axi_bvalid) begin
      s_axi_wready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= AXI_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= known_ofs(awaddr_q) ? AXI_OKAY : AXI_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= AXI_OKAY;
    end else if (rd_fire) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_val;
      s_axi_rresp   <= rd_ok ? AXI_OKAY : AXI_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ---------------- register state ----------------
  logic [15:0] count_q;
  logic [7:0]  gate_ctrl_q;     // bit GC_VAL unused; live value muxed on read
  logic        timer_on_q;
  logic [7:0]  short_count_q, period_q;
  logic [6:0]  short_ctrl_q;
  logic [2:0]  flags_q, irq_en_q;
  logic [4:0]  trig_cfg_q;
  logic        go_done_q;

  wire w_cnt_lo = wr_hit(awaddr_q, OFS_COUNT_LOW, wr_fire, wstrb_q);
  wire w_cnt_hi = wr_hit(awaddr_q, OFS_COUNT_HIGH, wr_fire, wstrb_q);
  wire w_gctl   = wr_hit(awaddr_q, OFS_GATE_CONTROL, wr_fire, wstrb_q);
  wire w_sc     = wr_hit(awaddr_q, OFS_SHORT_COUNT, wr_fire, wstrb_q);
  wire w_sctl   = wr_hit(awaddr_q, OFS_SHORT_CONTROL, wr_fire, wstrb_q);
  wire w_flags  = wr_hit(awaddr_q, OFS_FLAGS, wr_fire, wstrb_q);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gate_ctrl_q  <= RST_CTRL;
      timer_on_q   <= 1'b0;
      period_q     <= RST_PERIOD;
      short_ctrl_q <= '0;
      irq_en_q     <= '0;
      trig_cfg_q   <= '0;
    end else if (wr_fire && wstrb_q[0]) begin
      case (awaddr_q)
        OFS_GATE_CONTROL:  gate_ctrl_q  <= wdata_q[7:0];
        OFS_TIMER_CONTROL: timer_on_q   <= wdata_q[TC_ON];
        OFS_PERIOD:        period_q     <= wdata_q[7:0];
        OFS_SHORT_CONTROL: short_ctrl_q <= wdata_q[6:0];
        OFS_IRQ_ENABLE:    irq_en_q     <= wdata_q[2:0];
        OFS_TRIGGER:       trig_cfg_q   <= wdata_q[4:0];
        default: ;
      endcase
    end
  end

  // ---------------- gate and trigger input synchronisers ----------------
  logic [2:0] pin_s_q, c1_s_q, c2_s_q, trg_s_q;
  logic       pin_lvl_q, c1_lvl_q, c2_lvl_q, trg_lvl_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_s_q <= '0;
      c1_s_q  <= '0;
      c2_s_q  <= '0;
      trg_s_q <= '0;
    end else begin
      pin_s_q <= {pin_s_q[1:0], gate_input_pin};
      c1_s_q  <= {c1_s_q[1:0], cmp1_out};
      c2_s_q  <= {c2_s_q[1:0], cmp2_out};
      trg_s_q <= {trg_s_q[1:0], compare_trigger};
    end
  end
  // a level is accepted only when stages two and three agree
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_lvl_q <= 1'b0;
      c1_lvl_q  <= 1'b0;
      c2_lvl_q  <= 1'b0;
      trg_lvl_q <= 1'b0;
    end else begin
      if (pin_s_q[1] == pin_s_q[2]) pin_lvl_q <= pin_s_q[2];
      if (c1_s_q[1] == c1_s_q[2])   c1_lvl_q  <= c1_s_q[2];
      if (c2_s_q[1] == c2_s_q[2])   c2_lvl_q  <= c2_s_q[2];
      if (trg_s_q[1] == trg_s_q[2]) trg_lvl_q <= trg_s_q[2];
    end
  end

  // ---------------- short period-match timer ----------------
  logic [1:0] instr_q;
  logic [3:0] pre_q, post_q;
  logic       match_pulse_q;
  wire        instr_tick = (instr_q == 2'(INSTR_DIV - 1));
  wire        short_on   = short_ctrl_q[SC_ON];
  logic [3:0] pre_lim;
  always_comb begin
    case (short_ctrl_q[SC_PS_LSB +: 2])
      2'h0:    pre_lim = 4'h0;
      2'h1:    pre_lim = 4'h3;
      default: pre_lim = 4'hf;
    endcase
  end
  wire pre_tick   = short_on && instr_tick && (pre_q == pre_lim);
  wire short_wrap = pre_tick && (short_count_q == period_q);
  wire post_tick  = short_wrap && (post_q == short_ctrl_q[SC_POST_LSB +: 4]);

  always_ff @(posedge aclk) begin
    if (!aresetn) instr_q <= '0;
    else          instr_q <= instr_q + 2'h1;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || w_sc || w_sctl) begin
      pre_q  <= '0;
      post_q <= '0;
    end else begin
      if (short_on && instr_tick) pre_q <= pre_tick ? 4'h0 : pre_q + 4'h1;
      if (short_wrap) post_q <= post_tick ? 4'h0 : post_q + 4'h1;
    end
  end

  // a control write leaves the count alone
  always_ff @(posedge aclk) begin
    if (!aresetn)        short_count_q <= '0;
    else if (w_sc)       short_count_q <= wdata_q[7:0];
    else if (short_wrap) short_count_q <= 8'h00;
    else if (pre_tick)   short_count_q <= short_count_q + 8'h01;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) match_pulse_q <= 1'b0;
    else          match_pulse_q <= short_wrap;
  end

  // ---------------- gate path ----------------
  logic raw_src, pol_src;
  always_comb begin
    case (gate_ctrl_q[GC_SEL_LSB +: 2])
      SRC_PIN:   raw_src = pin_lvl_q;
      SRC_MATCH: raw_src = match_pulse_q;
      SRC_CMP1:  raw_src = c1_lvl_q;
      SRC_CMP2:  raw_src = c2_lvl_q;
      default:   raw_src = 1'b0;
    endcase
    pol_src = gate_ctrl_q[GC_POL] ? raw_src : !raw_src;
  end

  logic pol_prev_q, tog_q, tm_out, tm_prev_q, gate_val_q, gval_prev_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) pol_prev_q <= 1'b0;
    else          pol_prev_q <= pol_src;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || !gate_ctrl_q[GC_TM]) tog_q <= 1'b0;
    else if (pol_src && !pol_prev_q)     tog_q <= !tog_q;
  end
  assign tm_out = gate_ctrl_q[GC_TM] ? tog_q : pol_src;

  always_ff @(posedge aclk) begin
    if (!aresetn) tm_prev_q <= 1'b0;
    else          tm_prev_q <= tm_out;
  end
  wire tm_rise = tm_out && !tm_prev_q;
  wire tm_fall = !tm_out && tm_prev_q;

  // single pulse: go/done arms, the pulse window opens on the rising edge
  logic sp_open_q;
  always_ff @(posedge aclk) begin
    if (!aresetn || !gate_ctrl_q[GC_SPM])     sp_open_q <= 1'b0;
    else if (go_done_q && tm_rise)            sp_open_q <= 1'b1;
    else if (tm_fall)                         sp_open_q <= 1'b0;
  end

  // software sets go/done only while single pulse mode is enabled
  always_ff @(posedge aclk) begin
    if (!aresetn)                                          go_done_q <= 1'b0;
    else if (w_gctl && !wdata_q[GC_SPM])                   go_done_q <= 1'b0;
    else if (!gate_ctrl_q[GC_SPM])                         go_done_q <= 1'b0;
    else if (w_gctl)                                       go_done_q <= wdata_q[GC_GO];
    else if (sp_open_q && tm_fall)                         go_done_q <= 1'b0;
  end

  wire gate_level = gate_ctrl_q[GC_SPM] ? (sp_open_q && tm_out) : tm_out;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gate_val_q  <= 1'b0;
      gval_prev_q <= 1'b0;
    end else begin
      gate_val_q  <= gate_level;
      gval_prev_q <= gate_val_q;
    end
  end

  // ---------------- 16-bit counter ----------------
  wire count_en  = timer_on_q && (!gate_ctrl_q[GC_GE] || gate_val_q);
  wire trg_hit   = (trig_cfg_q[TR_MODE_LSB +: 4] == SPECIAL_EVENT_MODE)
                   && !trig_cfg_q[TR_ASYNC] && trg_lvl_q;
  wire wrap      = count_en && (count_q == COUNT_MAX);

  always_ff @(posedge aclk) begin
    if (!aresetn)      count_q <= RST_COUNT;
    else if (w_cnt_lo) count_q <= {count_q[15:8], wdata_q[7:0]};
    else if (w_cnt_hi) count_q <= {wdata_q[7:0], count_q[7:0]};
    else if (trg_hit)  count_q <= RST_COUNT;
    else if (count_en) count_q <= count_q + 16'h0001;
  end

  // set wins over a coincident software clear
  wire [2:0] set_ev = {post_tick,
                       gval_prev_q && !gate_val_q,
                       wrap && !w_cnt_lo && !w_cnt_hi && !trg_hit};
  always_ff @(posedge aclk) begin
    if (!aresetn)     flags_q <= '0;
    else if (w_flags) flags_q <= (flags_q & ~wdata_q[2:0]) | set_ev;
    else              flags_q <= flags_q | set_ev;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      overflow_irq    <= 1'b0;
      gate_event_irq  <= 1'b0;
      short_timer_irq <= 1'b0;
    end else begin
      overflow_irq    <= flags_q[FL_OVF] && irq_en_q[FL_OVF];
      gate_event_irq  <= flags_q[FL_GATE] && irq_en_q[FL_GATE];
      short_timer_irq <= flags_q[FL_SHORT] && irq_en_q[FL_SHORT];
    end
  end

  // ---------------- read mux ----------------
  always_comb begin
    rd_val = '0;
    rd_ok  = 1'b1;
    case (s_axi_araddr)
      OFS_COUNT_LOW:     rd_val[7:0] = count_q[7:0];
      OFS_COUNT_HIGH:    rd_val[7:0] = count_q[15:8];
      OFS_GATE_CONTROL:  rd_val[7:0] = {gate_ctrl_q[7:4], go_done_q, gate_val_q, gate_ctrl_q[1:0]};
      OFS_TIMER_CONTROL: rd_val[TC_ON] = timer_on_q;
      OFS_SHORT_COUNT:   rd_val[7:0] = short_count_q;
      OFS_PERIOD:        rd_val[7:0] = period_q;
      OFS_SHORT_CONTROL: rd_val[6:0] = short_ctrl_q;
      OFS_FLAGS:         rd_val[2:0] = flags_q;
      OFS_IRQ_ENABLE:    rd_val[2:0] = irq_en_q;
      OFS_TRIGGER:       rd_val[4:0] = trig_cfg_q;
      default:           rd_ok = 1'b0;
    endcase
  end
endmodule : gtm_top
`default_nettype wire

// file: testbench/gtm_chk.sv
// assertion checker for the gated timer bus handshake and interrupt outputs
`timescale 1ns/1ps
`default_nettype none
module gtm_chk
  import gtm_pkg::*;
(
  input wire logic              aclk,
  input wire logic              aresetn,
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_bready,
  input wire logic [AXI_AW-1:0] s_axi_araddr,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic [31:0]       s_axi_rdata,
  input wire logic [1:0]        s_axi_rresp,
  input wire logic              s_axi_rvalid,
  input wire logic              s_axi_rready,
  input wire logic              overflow_irq,
  input wire logic              gate_event_irq,
  input wire logic              short_timer_irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_read_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  a_write_latency: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid) else $error("write answer late");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped");
  a_one_read: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("second read accepted");
  a_unmapped_read: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr >= 8'h28
    |=> s_axi_rresp == AXI_SLVERR && s_axi_rdata == 32'h0) else $error("unmapped read not refused");
  a_ovf_irq_sticky: assert property ($fell(overflow_irq) |-> $past(s_axi_bvalid))
    else $error("overflow irq fell without a write");
  a_gate_irq_sticky: assert property ($fell(gate_event_irq) |-> $past(s_axi_bvalid))
    else $error("gate irq fell without a write");
  a_short_irq_sticky: assert property ($fell(short_timer_irq) |-> $past(s_axi_bvalid))
    else $error("short irq fell without a write");

  c_ovf: cover property (overflow_irq);
  c_gate: cover property (gate_event_irq);
  c_short: cover property (short_timer_irq);
endmodule : gtm_chk

bind gtm_top gtm_chk u_chk (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .overflow_irq(overflow_irq), .gate_event_irq(gate_event_irq), .short_timer_irq(short_timer_irq));
`default_nettype wire

// file: testbench/gtm_tb_top.sv
// self-checking bench for the gated timer with period-match companion
`timescale 1ns/1ps
`default_nettype none
module gtm_tb_top;
  import gtm_pkg::*;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, pin, cmp1, cmp2, trig;
  logic        awready, wready, bvalid, arready, rvalid, ovf_irq, gev_irq, sht_irq;
  logic [7:0]  awaddr, araddr;
  logic [31:0] rdata, wdata, v, w0;
  logic [1:0]  bresp, rresp, rr, br;
  int          fails = 0;
  int          cmp_count = 0;
  int          n;
  logic [7:0]  sc[3] = '{8'h04, 8'h0c, 8'h05};
  int          ex[3] = '{16, 32, 64};

  gtm_top uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .gate_input_pin(pin), .cmp1_out(cmp1), .cmp2_out(cmp2),
    .compare_trigger(trig), .overflow_irq(ovf_irq), .gate_event_irq(gev_irq), .short_timer_irq(sht_irq));

  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : results

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask : chk

  task automatic cyc(input int k);
    repeat (k) @(posedge aclk);
  endtask : cyc

  // trailing edge keeps the next call from reassigning a strobe in the same step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    br = bresp;
    bready <= 1'b0;
    @(posedge aclk);
    if (n == 50) begin
      fails++;
      results();
    end
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    d = rdata;
    rr = rresp;
    rready <= 1'b0;
    @(posedge aclk);
    if (n == 50) begin
      fails++;
      results();
    end
  endtask : rd

  task automatic gsrc(input int s, input logic b);
    case (s)
      0: pin <= b;
      2: cmp1 <= b;
      default: cmp2 <= b;
    endcase
  endtask : gsrc

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, pin, cmp1, cmp2, trig} = '0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(OFS_PERIOD, v);
    chk(v, {24'h0, RST_PERIOD}, "period reset");
    chk({30'h0, rr}, {30'h0, AXI_OKAY}, "read resp");
    rd(OFS_GATE_CONTROL, v);
    chk(v & 32'hfb, 32'h0, "gate control reset");
    rd(8'h30, v);
    chk({30'h0, rr}, {30'h0, AXI_SLVERR}, "unmapped resp");
    wr(8'h30, 32'h0);
    chk({30'h0, br}, {30'h0, AXI_SLVERR}, "unmapped write resp");
    $display("test reset done");
    // counting runs freely with gating off, wraps ffff to 0000
    wr(OFS_IRQ_ENABLE, 32'h1);
    chk({30'h0, br}, {30'h0, AXI_OKAY}, "write resp");
    wr(OFS_COUNT_HIGH, 32'hff);
    wr(OFS_COUNT_LOW, 32'hf0);
    wr(OFS_TIMER_CONTROL, 32'h1);
    for (n = 0; n < 40 && ovf_irq !== 1'b1; n++) @(posedge aclk);
    chk(ovf_irq, 1, "overflow irq");
    if (n == 40) results();
    wr(OFS_IRQ_ENABLE, 32'h0);
    chk(ovf_irq, 0, "overflow masked");
    rd(OFS_FLAGS, v);
    chk(v[0], 1, "overflow flag kept");
    wr(OFS_FLAGS, 32'h1);
    wr(OFS_IRQ_ENABLE, 32'h1);
    chk(ovf_irq, 0, "overflow cleared");
    $display("test overflow done");
    // trigger holds a count near ffff at zero without an overflow
    wr(OFS_TIMER_CONTROL, 32'h0);
    wr(OFS_COUNT_HIGH, 32'hff);
    wr(OFS_COUNT_LOW, 32'hfe);
    wr(OFS_TRIGGER, {28'h0, SPECIAL_EVENT_MODE});
    trig <= 1'b1;
    cyc(8);
    wr(OFS_TIMER_CONTROL, 32'h1);
    cyc(20);
    rd(OFS_COUNT_HIGH, v);
    chk(v, 32'h0, "trigger reset");
    rd(OFS_FLAGS, v);
    chk(v[0], 0, "trigger no overflow");
    wr(OFS_TRIGGER, {27'h1, SPECIAL_EVENT_MODE});
    cyc(4);
    rd(OFS_COUNT_LOW, v);
    chk(v != 32'h0, 1, "async ignores trigger");
    trig <= 1'b0;
    $display("test trigger done");
    // gate sources, polarity, live value and falling-edge event
    wr(OFS_IRQ_ENABLE, 32'h3);
    for (int s = 0; s < 4; s++) begin
      if (s == 1) continue;
      wr(OFS_GATE_CONTROL, 32'h40 | s);
      gsrc(s, 1'b1);
      cyc(8);
      rd(OFS_GATE_CONTROL, v);
      chk(v[2], 1, "gate high");
      wr(OFS_FLAGS, 32'h2);
      gsrc(s, 1'b0);
      cyc(8);
      rd(OFS_GATE_CONTROL, v);
      chk(v[2], 0, "gate low");
      rd(OFS_FLAGS, v);
      chk(v[1], 1, "gate event flag");
      chk(gev_irq, 1, "gate event irq");
      wr(OFS_GATE_CONTROL, s);
      rd(OFS_GATE_CONTROL, v);
      chk(v[2], 1, "inverted gate");
    end
    wr(OFS_GATE_CONTROL, 32'h60);
    pin <= 1'b1;
    cyc(8);
    pin <= 1'b0;
    cyc(8);
    rd(OFS_GATE_CONTROL, v);
    chk(v[2], 1, "toggled gate");
    wr(OFS_GATE_CONTROL, 32'h40);
    // re-enabling toggle shows whether the flip-flop was held clear
    wr(OFS_GATE_CONTROL, 32'h60);
    rd(OFS_GATE_CONTROL, v);
    chk(v[2], 0, "toggle cleared");
    $display("test gate done");
    // single pulse: arm, count one pulse, then ignore the next
    wr(OFS_GATE_CONTROL, 32'hd0);
    wr(OFS_GATE_CONTROL, 32'hd8);
    rd(OFS_GATE_CONTROL, v);
    chk(v[3], 1, "armed");
    rd(OFS_COUNT_LOW, w0);
    pin <= 1'b1;
    cyc(10);
    pin <= 1'b0;
    cyc(8);
    rd(OFS_GATE_CONTROL, v);
    chk(v[3], 0, "done after pulse");
    rd(OFS_COUNT_LOW, v);
    chk(v != w0, 1, "pulse counted");
    w0 = v;
    pin <= 1'b1;
    cyc(10);
    pin <= 1'b0;
    cyc(8);
    rd(OFS_COUNT_LOW, v);
    chk(v, w0, "second pulse ignored");
    wr(OFS_GATE_CONTROL, 32'hd8);
    wr(OFS_GATE_CONTROL, 32'hc8);
    rd(OFS_GATE_CONTROL, v);
    chk(v[3], 0, "go cleared with mode");
    rd(OFS_COUNT_LOW, w0);
    cyc(8);
    rd(OFS_COUNT_LOW, v);
    chk(v, w0, "gated count holds");
    wr(OFS_GATE_CONTROL, 32'hf0);
    wr(OFS_GATE_CONTROL, 32'hf8);
    pin <= 1'b1;
    cyc(10);
    pin <= 1'b0;
    cyc(10);
    rd(OFS_GATE_CONTROL, v);
    chk(v[3], 1, "toggled pulse still armed");
    pin <= 1'b1;
    cyc(10);
    pin <= 1'b0;
    cyc(8);
    rd(OFS_GATE_CONTROL, v);
    chk(v[3], 0, "toggled pulse done");
    $display("test single pulse done");
    // short timer period with prescale and postscale
    wr(OFS_IRQ_ENABLE, 32'h4);
    wr(OFS_PERIOD, 32'h3);
    for (int k = 0; k < 3; k++) begin
      wr(OFS_SHORT_CONTROL, 32'h0);
      wr(OFS_FLAGS, 32'h4);
      wr(OFS_SHORT_COUNT, 32'h0);
      wr(OFS_SHORT_CONTROL, {24'h0, sc[k]});
      for (n = 0; n < 100 && sht_irq !== 1'b1; n++) @(posedge aclk);
      chk(n > ex[k] - 8 && n < ex[k] + 4, 1, "short period");
      if (n == 100) results();
    end
    wr(OFS_SHORT_COUNT, 32'h2);
    wr(OFS_SHORT_CONTROL, 32'h0);
    rd(OFS_SHORT_COUNT, v);
    chk(v, 32'h2, "control write keeps count");
    wr(OFS_SHORT_CONTROL, 32'h4);
    wr(OFS_GATE_CONTROL, 32'h41);
    wr(OFS_FLAGS, 32'h2);
    cyc(40);
    rd(OFS_FLAGS, v);
    chk(v[1], 1, "match pulse gate");
    $display("test short timer done");
    results();
  end
endmodule : gtm_tb_top
`default_nettype wire
